// file: include/bkrc_pkg.sv
package bkrc_pkg;
    localparam logic [11:0] ADDR_VOLT = 12'h000;
    localparam logic [11:0] ADDR_RUN_MODE = 12'h004;
    localparam logic [11:0] ADDR_STBY_MODE = 12'h008;
    localparam logic [11:0] ADDR_ILIM = 12'h00C;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h010;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h014;
    localparam logic [11:0] ADDR_STATE = 12'h018;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] MODE_SEQ_DEFAULT = 2'h3;
    localparam logic [1:0] MODE_NOSEQ_DEFAULT = 2'h0;
    localparam logic [1:0] ILIM_RESET = 2'h0;
    localparam logic MASK_RESET = 1'b1;
    localparam logic [4:0] CODE_TOP = 5'h1B;
    // Discharge time before re-enable, 100 ns clock.
    localparam int DISCHARGE_US = 100;
    localparam int CLK_NS = 100;
    localparam int DISCHARGE_CYC = DISCHARGE_US * 1000 / CLK_NS;
    localparam int DIS_W = 10;

    typedef enum logic [1:0] {
        BKRC_OFF = 2'b00,
        BKRC_PWM = 2'b01,
        BKRC_PFM = 2'b10,
        BKRC_AUTO = 2'b11
    } bkrc_mode_e;

    typedef enum logic [1:0] {
        BKRC_ST_IDLE = 2'b00,
        BKRC_ST_ON = 2'b01,
        BKRC_ST_DISCHARGE = 2'b10
    } bkrc_seq_e;
endpackage

// file: src/bkrc_vdecode.sv
`timescale 1ns/1ps
module bkrc_vdecode
    import bkrc_pkg::*;
(
    input wire logic [4:0] i_code,
    output logic [12:0] o_millivolt
);
    logic [4:0] sat;

    always_comb begin
        sat = (i_code > CODE_TOP) ? CODE_TOP : i_code;
        case (sat)
            5'h00: o_millivolt = 13'h03E8;
            5'h01: o_millivolt = 13'h044C;
            5'h02: o_millivolt = 13'h04B0;
            5'h03: o_millivolt = 13'h04E2;
            5'h04: o_millivolt = 13'h0514;
            5'h05: o_millivolt = 13'h0546;
            5'h06: o_millivolt = 13'h05DC;
            5'h07: o_millivolt = 13'h0640;
            5'h08: o_millivolt = 13'h0708;
            5'h09: o_millivolt = 13'h073A;
            5'h0A: o_millivolt = 13'h07D0;
            5'h0B: o_millivolt = 13'h0834;
            5'h0C: o_millivolt = 13'h0866;
            5'h0D: o_millivolt = 13'h08CA;
            5'h0E: o_millivolt = 13'h08FC;
            5'h0F: o_millivolt = 13'h0960;
            5'h10: o_millivolt = 13'h09C4;
            5'h11: o_millivolt = 13'h0AF0;
            5'h12: o_millivolt = 13'h0C4E;
            5'h13: o_millivolt = 13'h0C80;
            5'h14: o_millivolt = 13'h0CB2;
            5'h15: o_millivolt = 13'h0CE4;
            5'h16: o_millivolt = 13'h0D16;
            5'h17: o_millivolt = 13'h0D48;
            5'h18: o_millivolt = 13'h0DAC;
            5'h19: o_millivolt = 13'h0ED8;
            5'h1A: o_millivolt = 13'h0FA0;
            default: o_millivolt = 13'h1004;
        endcase
    end
endmodule // bkrc_vdecode

// file: src/bkrc_ilim_decode.sv
`timescale 1ns/1ps
module bkrc_ilim_decode
    import bkrc_pkg::*;
(
    input wire logic [1:0] i_sel,
    output logic [12:0] o_milliamp
);
    always_comb begin
        case (i_sel)
            2'h0: o_milliamp = 13'h0834;
            2'h1: o_milliamp = 13'h0A28;
            2'h2: o_milliamp = 13'h0BB8;
            default: o_milliamp = 13'h1194;
        endcase
    end
endmodule // bkrc_ilim_decode

// file: src/bkrc_top.sv
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module bkrc_top
    import bkrc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [4:0] i_default_voltage_code_otp,
    input wire logic i_otp_in_sequence,
    input wire logic i_standby,
    input wire logic [11:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [11:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    output logic [4:0] o_out_voltage_code,
    output logic [12:0] o_setpoint_mv,
    output logic [1:0] o_active_mode,
    output logic o_buck_enable,
    output logic o_discharge,
    output logic [1:0] o_peak_limit_select,
    output logic [12:0] o_peak_limit_ma,
    output logic o_irq_out_n
);
    logic [4:0] out_voltage_code;
    logic [1:0] run_state_op_select;
    logic [1:0] standby_state_op_select;
    logic [1:0] peak_limit_select;
    logic op_change_irq_flag;
    logic irq_mask;
    logic loaded;
    logic aw_held;
    logic w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic do_write;
    logic volt_write;
    logic clear_flag;
    bkrc_mode_e mode_sel;
    bkrc_mode_e applied_mode;
    bkrc_seq_e seq;
    bkrc_seq_e next_seq;
    bkrc_mode_e next_applied;
    logic [DIS_W-1:0] dis_count;
    logic [12:0] setpoint_mv;
    logic [12:0] limit_ma;
    logic [1:0] mode_reset;

    // Write path: address and data are taken independently, then answered together.
    assign o_s_axi_awready = !aw_held && !bvalid;
    assign o_s_axi_wready = !w_held && !bvalid;
    assign o_s_axi_arready = !rvalid;
    assign do_write = aw_held && w_held && !bvalid;
    assign volt_write = do_write && (aw_addr == ADDR_VOLT) && w_strb[0];
    assign clear_flag = do_write && (aw_addr == ADDR_IRQ_STATUS) && w_strb[0] && w_data[0];

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else begin
            if (o_s_axi_awready && i_s_axi_awvalid) begin
                aw_held <= 1'b1;
                aw_addr <= i_s_axi_awaddr;
            end
            if (o_s_axi_wready && i_s_axi_wvalid) begin
                w_held <= 1'b1;
                w_data <= i_s_axi_wdata;
                w_strb <= i_s_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= (aw_addr[11:5] == 7'h00 && aw_addr[1:0] == 2'h0
                          && aw_addr[4:2] != 3'h7) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && i_s_axi_bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    assign o_s_axi_bvalid = bvalid;
    assign o_s_axi_bresp = bresp;

    assign mode_reset = i_otp_in_sequence ? MODE_SEQ_DEFAULT : MODE_NOSEQ_DEFAULT;

    // Reset clears the load flag and the registers except irq_mask, which it sets; the OTP straps are sampled on the first clock after.
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            loaded <= 1'b0;
            out_voltage_code <= 5'h00;
            run_state_op_select <= 2'h0;
            standby_state_op_select <= 2'h0;
            peak_limit_select <= ILIM_RESET;
            irq_mask <= MASK_RESET;
        end else if (!loaded) begin
            loaded <= 1'b1;
            out_voltage_code <= i_default_voltage_code_otp;
            run_state_op_select <= mode_reset;
            standby_state_op_select <= mode_reset;
        end else if (do_write && w_strb[0]) begin
            case (aw_addr)
                ADDR_VOLT: out_voltage_code <= w_data[4:0];
                ADDR_RUN_MODE: run_state_op_select <= w_data[1:0];
                ADDR_STBY_MODE: standby_state_op_select <= w_data[1:0];
                ADDR_ILIM: peak_limit_select <= w_data[1:0];
                ADDR_IRQ_MASK: irq_mask <= w_data[0];
                default: ;
            endcase
        end
    end

    // The state input only picks a field; voltage code is untouched across states.
    assign mode_sel = bkrc_mode_e'(i_standby ? standby_state_op_select
                                             : run_state_op_select);

    // Sequencer: a new code while regulating forces a discharge before restart.
    always_comb begin
        next_seq = seq;
        case (seq)
            BKRC_ST_IDLE: if (loaded && mode_sel != BKRC_OFF) next_seq = BKRC_ST_ON;
            BKRC_ST_ON: begin
                if (volt_write) next_seq = BKRC_ST_DISCHARGE;
                else if (mode_sel == BKRC_OFF) next_seq = BKRC_ST_IDLE;
            end
            BKRC_ST_DISCHARGE: begin
                if (dis_count == DIS_W'(DISCHARGE_CYC - 1)) begin
                    next_seq = (mode_sel == BKRC_OFF) ? BKRC_ST_IDLE : BKRC_ST_ON;
                end
            end
            default: next_seq = BKRC_ST_IDLE;
        endcase
    end

    // One shared next value keeps the flag in step with what the regulator is given.
    assign next_applied = (next_seq == BKRC_ST_ON) ? mode_sel : BKRC_OFF;

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            seq <= BKRC_ST_IDLE;
        end else begin
            seq <= next_seq;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            dis_count <= '0;
        end else if (seq == BKRC_ST_DISCHARGE) begin
            dis_count <= dis_count + 1'b1;
        end else begin
            dis_count <= '0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            applied_mode <= BKRC_OFF;
        end else begin
            applied_mode <= next_applied;
        end
    end

    // Set wins over a simultaneous clear so no mode change is missed.
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            op_change_irq_flag <= 1'b0;
        end else if (loaded && applied_mode != next_applied) begin
            op_change_irq_flag <= 1'b1;
        end else if (clear_flag) begin
            op_change_irq_flag <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_irq_out_n <= 1'b1;
        end else begin
            o_irq_out_n <= !(op_change_irq_flag && !irq_mask);
        end
    end

    bkrc_vdecode u_vdecode (
        .i_code(out_voltage_code),
        .o_millivolt(setpoint_mv)
    );

    bkrc_ilim_decode u_ilim (
        .i_sel(peak_limit_select),
        .o_milliamp(limit_ma)
    );

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_out_voltage_code <= 5'h00;
            o_setpoint_mv <= 13'h0000;
            o_active_mode <= 2'h0;
            o_buck_enable <= 1'b0;
            o_discharge <= 1'b0;
            o_peak_limit_select <= 2'h0;
            o_peak_limit_ma <= 13'h0000;
        end else begin
            o_out_voltage_code <= out_voltage_code;
            o_setpoint_mv <= setpoint_mv;
            o_active_mode <= applied_mode;
            o_buck_enable <= (applied_mode != BKRC_OFF);
            o_discharge <= (seq == BKRC_ST_DISCHARGE);
            o_peak_limit_select <= peak_limit_select;
            o_peak_limit_ma <= limit_ma;
        end
    end

    // Read path.
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else if (i_s_axi_arvalid && !rvalid) begin
            rvalid <= 1'b1;
            rresp <= RESP_OKAY;
            case (i_s_axi_araddr)
                ADDR_VOLT: rdata <= {27'h0, out_voltage_code};
                ADDR_RUN_MODE: rdata <= {30'h0, run_state_op_select};
                ADDR_STBY_MODE: rdata <= {30'h0, standby_state_op_select};
                ADDR_ILIM: rdata <= {30'h0, peak_limit_select};
                ADDR_IRQ_STATUS: rdata <= {31'h0, op_change_irq_flag};
                ADDR_IRQ_MASK: rdata <= {31'h0, irq_mask};
                ADDR_STATE: rdata <= {28'h0, seq, applied_mode};
                default: begin
                    rdata <= 32'h0000_0000;
                    rresp <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid && i_s_axi_rready) begin
            rvalid <= 1'b0;
        end
    end

    assign o_s_axi_rvalid = rvalid;
    assign o_s_axi_rdata = rdata;
    assign o_s_axi_rresp = rresp;

    // Power-up load of the one-time defaults.
    AST_OTP_LOAD: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        $rose(loaded) |-> out_voltage_code == $past(i_default_voltage_code_otp))
        else $error("Voltage code not loaded from OTP.");
    AST_MODE_DEFAULT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        $rose(loaded) |-> run_state_op_select == standby_state_op_select)
        else $error("Mode defaults differ.");
    AST_MODE_LOAD: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        $rose(loaded) |-> run_state_op_select == $past(mode_reset))
        else $error("Run mode not loaded from the sequence strap.");
    AST_LOAD_ONCE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        loaded |=> loaded)
        else $error("Defaults reloaded outside reset.");

    // Discharge sequence around a voltage change, and code saturation.
    AST_DISCHARGE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (seq == BKRC_ST_ON && volt_write) |=> seq == BKRC_ST_DISCHARGE)
        else $error("No discharge after voltage change.");
    AST_OFF_IN_DIS: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        seq == BKRC_ST_DISCHARGE |=> applied_mode == BKRC_OFF || seq != BKRC_ST_DISCHARGE)
        else $error("Regulator on while discharging.");
    AST_DIS_LEN: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        seq == BKRC_ST_DISCHARGE |-> dis_count < DIS_W'(DISCHARGE_CYC))
        else $error("Discharge counter ran past its limit.");
    AST_DIS_EXIT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (seq == BKRC_ST_DISCHARGE && dis_count == DIS_W'(DISCHARGE_CYC - 1))
        |=> seq != BKRC_ST_DISCHARGE)
        else $error("Discharge did not end on time.");
    AST_SAT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        out_voltage_code >= CODE_TOP |-> setpoint_mv == 13'h1004)
        else $error("Saturated code not 4.10 V.");

    // Applied mode, state selection and the interrupt path.
    AST_STBY_APPLY: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (seq == BKRC_ST_ON && next_seq == BKRC_ST_ON) |=> applied_mode == $past(mode_sel))
        else $error("Applied mode does not follow the selected field.");
    AST_ENABLE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_buck_enable == (o_active_mode != 2'h0))
        else $error("Enable disagrees with the applied mode.");
    AST_STBY_VOLT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        ($changed(i_standby) && !do_write) |=> $stable(out_voltage_code))
        else $error("Voltage changed on state toggle.");
    AST_IRQ_SET: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (loaded && $changed(applied_mode)) |-> op_change_irq_flag)
        else $error("Mode change without flag.");
    AST_IRQ_OUT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (op_change_irq_flag && !irq_mask) |=> !o_irq_out_n)
        else $error("Interrupt output not driven.");
    AST_IRQ_RELEASE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (!op_change_irq_flag || irq_mask) |=> o_irq_out_n)
        else $error("Interrupt output held with nothing pending.");
    AST_FLAG_HOLD: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (op_change_irq_flag && !clear_flag) |=> op_change_irq_flag)
        else $error("Flag dropped without clear.");
    AST_FLAG_CLEAR: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (clear_flag && applied_mode == next_applied) |=> !op_change_irq_flag)
        else $error("Flag not cleared by software.");

    // Register bus writes and reads are answered, and the answers hold until taken.
    AST_WR_RESP: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        do_write |=> bvalid)
        else $error("Write not answered.");
    AST_B_HOLD: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (bvalid && !i_s_axi_bready) |=> bvalid && $stable(bresp))
        else $error("Write response dropped before taken.");
    AST_AR_TAKE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_s_axi_arvalid && !rvalid) |=> rvalid)
        else $error("Read not answered.");
    AST_R_HOLD: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (rvalid && !i_s_axi_rready) |=> rvalid && $stable(rdata))
        else $error("Read data dropped before taken.");

    // Main scenarios.
    COV_DISCHARGE: cover property (@(posedge i_clk) seq == BKRC_ST_DISCHARGE);
    COV_IRQ: cover property (@(posedge i_clk) !o_irq_out_n);
    COV_STBY: cover property (@(posedge i_clk) i_standby && applied_mode != BKRC_OFF);
    COV_DIS_DONE: cover property (@(posedge i_clk)
        seq == BKRC_ST_DISCHARGE ##1 seq == BKRC_ST_ON);
    COV_IRQ_CLEAR: cover property (@(posedge i_clk)
        op_change_irq_flag ##1 !op_change_irq_flag);
endmodule // bkrc_top

// file: bench/bkrc_host.sv
`timescale 1ns/1ps
module bkrc_host (
    input wire logic i_clk,
    output logic [11:0] o_awaddr,
    output logic o_awvalid,
    input wire logic i_awready,
    output logic [31:0] o_wdata,
    output logic [3:0] o_wstrb,
    output logic o_wvalid,
    input wire logic i_wready,
    input wire logic [1:0] i_bresp,
    input wire logic i_bvalid,
    output logic o_bready,
    output logic [11:0] o_araddr,
    output logic o_arvalid,
    input wire logic i_arready,
    input wire logic [31:0] i_rdata,
    input wire logic [1:0] i_rresp,
    input wire logic i_rvalid,
    output logic o_rready,
    output logic o_timeout
);
    initial begin
        {o_awaddr, o_awvalid, o_wdata, o_wstrb, o_wvalid, o_bready} = '0;
        {o_araddr, o_arvalid, o_rready, o_timeout} = '0;
    end

    // Handshakes are judged on values taken at the falling edge, which equal what the
    // slave sees at the next rising edge, so no race with its combinational ready.
    task automatic write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw;
        logic w;
        logic b;
        r = 2'bxx;
        @(posedge i_clk);
        o_awaddr <= a;
        o_awvalid <= 1'b1;
        o_wdata <= d;
        o_wstrb <= 4'hF;
        o_wvalid <= 1'b1;
        o_bready <= 1'b1;
        for (int n = 0; n < 64; n++) begin
            @(negedge i_clk);
            aw = o_awvalid && i_awready;
            w = o_wvalid && i_wready;
            b = i_bvalid;
            r = i_bresp;
            @(posedge i_clk);
            if (aw) o_awvalid <= 1'b0;
            if (w) o_wvalid <= 1'b0;
            if (b) begin
                o_bready <= 1'b0;
                return;
            end
        end
        o_timeout <= 1'b1;
    endtask

    task automatic read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar;
        logic b;
        @(posedge i_clk);
        o_araddr <= a;
        o_arvalid <= 1'b1;
        o_rready <= 1'b1;
        for (int n = 0; n < 64; n++) begin
            @(negedge i_clk);
            ar = o_arvalid && i_arready;
            b = i_rvalid;
            d = i_rdata;
            r = i_rresp;
            @(posedge i_clk);
            if (ar) o_arvalid <= 1'b0;
            if (b) begin
                o_rready <= 1'b0;
                return;
            end
        end
        o_timeout <= 1'b1;
    endtask
endmodule // bkrc_host

// file: bench/tb_buck_regulator_control.sv
`timescale 1ns/1ps
module tb_buck_regulator_control
    import bkrc_pkg::*;
;
    logic i_clk, i_reset_n, i_otp_in_sequence, i_standby, tmo;
    logic [4:0] i_default_voltage_code_otp, o_out_voltage_code;
    logic [11:0] i_s_axi_awaddr, i_s_axi_araddr;
    logic [31:0] i_s_axi_wdata, o_s_axi_rdata, rd;
    logic [3:0] i_s_axi_wstrb;
    logic [1:0] o_s_axi_bresp, o_s_axi_rresp, o_active_mode, o_peak_limit_select, rr;
    logic i_s_axi_awvalid, o_s_axi_awready, i_s_axi_wvalid, o_s_axi_wready, o_s_axi_bvalid;
    logic i_s_axi_bready, i_s_axi_arvalid, o_s_axi_arready, o_s_axi_rvalid, i_s_axi_rready;
    logic o_buck_enable, o_discharge, o_irq_out_n;
    logic [12:0] o_peak_limit_ma, o_setpoint_mv;
    int err_count, compares, n;
    logic [12:0] mv_tab [27] = '{13'h3E8, 13'h44C, 13'h4B0, 13'h4E2, 13'h514, 13'h546, 13'h5DC,
        13'h640, 13'h708, 13'h73A, 13'h7D0, 13'h834, 13'h866, 13'h8CA, 13'h8FC, 13'h960,
        13'h9C4, 13'hAF0, 13'hC4E, 13'hC80, 13'hCB2, 13'hCE4, 13'hD16, 13'hD48, 13'hDAC,
        13'hED8, 13'hFA0};
    logic [12:0] ma_tab [4] = '{13'h834, 13'hA28, 13'hBB8, 13'h1194};

    bkrc_top dut (.i_clk, .i_reset_n, .i_default_voltage_code_otp, .i_otp_in_sequence,
        .i_standby, .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wdata,
        .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid,
        .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata,
        .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready, .o_out_voltage_code, .o_setpoint_mv,
        .o_active_mode, .o_buck_enable, .o_discharge, .o_peak_limit_select, .o_peak_limit_ma,
        .o_irq_out_n);

    bkrc_host u_host (.i_clk, .o_awaddr(i_s_axi_awaddr), .o_awvalid(i_s_axi_awvalid),
        .i_awready(o_s_axi_awready), .o_wdata(i_s_axi_wdata), .o_wstrb(i_s_axi_wstrb),
        .o_wvalid(i_s_axi_wvalid), .i_wready(o_s_axi_wready), .i_bresp(o_s_axi_bresp),
        .i_bvalid(o_s_axi_bvalid), .o_bready(i_s_axi_bready), .o_araddr(i_s_axi_araddr),
        .o_arvalid(i_s_axi_arvalid), .i_arready(o_s_axi_arready), .i_rdata(o_s_axi_rdata),
        .i_rresp(o_s_axi_rresp), .i_rvalid(o_s_axi_rvalid), .o_rready(i_s_axi_rready),
        .o_timeout(tmo));

    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    task automatic end_of_test();
        $display("Compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic settle(input int c);
        repeat (c) @(posedge i_clk);
        @(negedge i_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        u_host.write(a, d, rr);
        chk("bresp", 32'(RESP_OKAY), 32'(rr));
    endtask

    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        u_host.read(a, rd, rr);
        chk("rresp", 32'(RESP_OKAY), 32'(rr));
        chk(nm, e, rd);
    endtask

    task automatic do_reset(input logic seq, input logic [4:0] otp);
        @(posedge i_clk);
        i_reset_n <= 1'b0;
        i_otp_in_sequence <= seq;
        i_default_voltage_code_otp <= otp;
        repeat (20) @(posedge i_clk);
        i_reset_n <= 1'b1;
        settle(3);
    endtask

    // A stuck handshake or a runaway run both land in the single closing report.
    always @(posedge tmo) begin
        err_count++;
        end_of_test();
    end

    initial begin
        repeat (60000) @(posedge i_clk);
        err_count++;
        end_of_test();
    end

    initial begin
        {i_reset_n, i_standby, i_otp_in_sequence, i_default_voltage_code_otp} = '0;
        do_reset(1'b1, 5'h15);
        chk("code", 32'h15, 32'(o_out_voltage_code));
        chk("setpoint", 32'hCE4, 32'(o_setpoint_mv));
        chk("mode", 32'(MODE_SEQ_DEFAULT), 32'(o_active_mode));
        rdchk("run", ADDR_RUN_MODE, 32'(MODE_SEQ_DEFAULT));
        rdchk("stby", ADDR_STBY_MODE, 32'(MODE_SEQ_DEFAULT));
        rdchk("mask", ADDR_IRQ_MASK, 32'(MASK_RESET));
        rdchk("state", ADDR_STATE, 32'({BKRC_ST_ON, BKRC_AUTO}));
        chk("ilim rst", 32'(ILIM_RESET), 32'(o_peak_limit_select));
        u_host.write(12'h01C, 32'h1, rr);
        chk("wr slverr", 32'(RESP_SLVERR), 32'(rr));
        u_host.read(12'h01C, rd, rr);
        chk("slverr", 32'(RESP_SLVERR), 32'(rr));
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_RUN_MODE, 32'(m));
            settle(3);
            chk("mode", 32'(m), 32'(o_active_mode));
            chk("enable", 32'(m != 0), 32'(o_buck_enable));
        end
        wr(ADDR_STBY_MODE, 32'(BKRC_PFM));
        wr(ADDR_RUN_MODE, 32'(BKRC_PWM));
        @(posedge i_clk) i_standby <= 1'b1;
        settle(3);
        chk("stby mode", 32'(BKRC_PFM), 32'(o_active_mode));
        chk("stby code", 32'h15, 32'(o_out_voltage_code));
        @(posedge i_clk) i_standby <= 1'b0;
        settle(3);
        chk("run mode", 32'(BKRC_PWM), 32'(o_active_mode));
        chk("run code", 32'h15, 32'(o_out_voltage_code));
        wr(ADDR_IRQ_STATUS, 32'h1);
        wr(ADDR_IRQ_MASK, 32'h0);
        settle(2);
        chk("irq idle", 32'h1, 32'(o_irq_out_n));
        wr(ADDR_RUN_MODE, 32'(BKRC_AUTO));
        settle(10);
        chk("irq set", 32'h0, 32'(o_irq_out_n));
        rdchk("status", ADDR_IRQ_STATUS, 32'h1);
        wr(ADDR_IRQ_STATUS, 32'h1);
        settle(3);
        chk("irq clr", 32'h1, 32'(o_irq_out_n));
        wr(ADDR_IRQ_MASK, 32'h1);
        wr(ADDR_RUN_MODE, 32'(BKRC_PWM));
        settle(3);
        chk("irq masked", 32'h1, 32'(o_irq_out_n));
        rdchk("status masked", ADDR_IRQ_STATUS, 32'h1);
        wr(ADDR_VOLT, 32'h08);
        settle(2);
        chk("discharge", 32'h1, 32'(o_discharge));
        chk("disabled", 32'h0, 32'(o_buck_enable));
        for (n = 0; n < 1100 && o_buck_enable !== 1'b1; n++) @(negedge i_clk);
        if (n == 1100) begin
            err_count++;
            end_of_test();
        end
        chk("discharge cycles", 32'(DISCHARGE_CYC - 2), 32'(n));
        chk("new setpoint", 32'h708, 32'(o_setpoint_mv));
        chk("discharge end", 32'h0, 32'(o_discharge));
        wr(ADDR_RUN_MODE, 32'(BKRC_OFF));
        for (int c = 0; c < 32; c++) begin
            wr(ADDR_VOLT, 32'(c));
            settle(3);
            chk("code", 32'(c), 32'(o_out_voltage_code));
            chk("setpoint", 32'(c > 26 ? 13'h1004 : mv_tab[c]), 32'(o_setpoint_mv));
        end
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_ILIM, 32'(s));
            settle(3);
            chk("ilim", 32'(s), 32'(o_peak_limit_select));
            chk("ilim ma", 32'(ma_tab[s]), 32'(o_peak_limit_ma));
        end
        do_reset(1'b0, 5'h1F);
        chk("mode noseq", 32'(MODE_NOSEQ_DEFAULT), 32'(o_active_mode));
        chk("enable noseq", 32'h0, 32'(o_buck_enable));
        chk("setpoint top", 32'h1004, 32'(o_setpoint_mv));
        rdchk("run noseq", ADDR_RUN_MODE, 32'(MODE_NOSEQ_DEFAULT));
        rdchk("stby noseq", ADDR_STBY_MODE, 32'(MODE_NOSEQ_DEFAULT));
        end_of_test();
    end
endmodule // tb_buck_regulator_control
